//--- rtl/phy_regs_pkg.sv
`default_nettype none
package phy_regs_pkg;
    // Register indexes on the management access path.
    localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
    localparam logic [4:0] IDX_ID_HIGH      = 5'h02;
    localparam logic [4:0] IDX_ID_LOW       = 5'h03;
    localparam logic [4:0] IDX_ADVERTISE    = 5'h04;
    localparam logic [4:0] IDX_PARTNER      = 5'h05;

    localparam int REG_W = 16;

    // Basic status bit positions.
    localparam int STS_AN_DONE = 5;
    localparam int STS_RFAULT  = 4;
    localparam int STS_LINK    = 2;
    localparam int STS_JABBER  = 1;
    // T4 clear, four speed/duplex abilities, negotiation able and extended registers set.
    localparam logic [15:0] STATUS_FIXED = 16'h7809;
    localparam logic [15:0] STATUS_FIXED_MASK = 16'hf809;

    // Advertisement and partner ability bit positions.
    localparam int ADV_RFAULT  = 13;
    localparam int ADV_PAUSE_H = 11;
    localparam int ADV_PAUSE_L = 10;
    localparam int ADV_TX_FD   = 8;
    localparam int ADV_TX      = 7;
    localparam int ADV_10_FD   = 6;
    localparam int ADV_10      = 5;
    localparam int SEL_H       = 4;
    localparam int LP_NEXTPAGE = 15;
    localparam int LP_ACK      = 14;

    localparam logic [15:0] ADV_WR_MASK  = 16'h2dff;
    localparam logic [15:0] PARTNER_MASK = 16'h2fff;
    localparam logic [4:0]  SELECTOR_8023 = 5'h01;

    // Pause field encodings.
    localparam logic [1:0] PAUSE_NONE = 2'h0;
    localparam logic [1:0] PAUSE_SYM  = 2'h1;
    localparam logic [1:0] PAUSE_ASYM = 2'h2;
    localparam logic [1:0] PAUSE_BOTH = 2'h3;

    // Identifier field layout in the low identifier register.
    localparam int ID_OUI_L = 10;
    localparam int ID_MODEL_L = 4;
endpackage
`default_nettype wire

//--- rtl/latch_if.sv
`default_nettype none
interface latch_if;
    logic cond;
    logic clear;
    logic shown;
    modport owner (input cond, input clear, output shown);
    modport user  (output cond, output clear, input shown);
endinterface
`default_nettype wire

//--- rtl/status_latch.sv
`default_nettype none
module status_latch #(
    parameter bit LATCH_LOW = 1'b0
) (
    input  wire logic clock,
    input  wire logic rst,
    latch_if.owner    lat
);
    typedef struct packed {
        logic shown;
    } latch_state_t;

    latch_state_t s_q;
    latch_state_t s_d;

    // A read reloads the bit from the live condition; an event in that same cycle still wins.
    always_comb begin
        s_d = s_q;
        if (LATCH_LOW) begin
            s_d.shown = lat.cond & (lat.clear | s_q.shown);
        end else begin
            s_d.shown = lat.cond | (~lat.clear & s_q.shown);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lat.shown = s_q.shown;

    latch_hold_a: assert property (@(posedge clock) disable iff (rst)
        (!lat.clear && (LATCH_LOW ? !s_q.shown : s_q.shown)) |=> (s_q.shown == $past(s_q.shown)))
        else $error("latched status bit lost before it was read");
endmodule
`default_nettype wire

//--- rtl/pause_resolve.sv
`default_nettype none
module pause_resolve (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       an_complete,
    input  wire logic [1:0] adv_pause,
    input  wire logic [1:0] partner_pause,
    output logic      [1:0] pause_mode
);
    typedef struct packed {
        logic [1:0] mode;
    } pause_state_t;

    pause_state_t s_q;
    pause_state_t s_d;

    // Symmetric is preferred when both are offered, since it lets both ends throttle each other.
    always_comb begin
        s_d = s_q;
        if (!an_complete) begin
            s_d.mode = phy_regs_pkg::PAUSE_NONE;
        end else if (adv_pause == phy_regs_pkg::PAUSE_BOTH) begin
            if (partner_pause[0]) begin
                s_d.mode = phy_regs_pkg::PAUSE_SYM;
            end else if (partner_pause[1]) begin
                s_d.mode = phy_regs_pkg::PAUSE_ASYM;
            end else begin
                s_d.mode = phy_regs_pkg::PAUSE_NONE;
            end
        end else begin
            s_d.mode = adv_pause;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pause_mode = s_q.mode;

    single_pause_a: assert property (@(posedge clock) disable iff (rst)
        (an_complete && adv_pause == phy_regs_pkg::PAUSE_BOTH) |=> (pause_mode != phy_regs_pkg::PAUSE_BOTH))
        else $error("both pause kinds configured after negotiation");
    pause_idle_a: assert property (@(posedge clock) disable iff (rst)
        !an_complete |=> (pause_mode == phy_regs_pkg::PAUSE_NONE))
        else $error("pause configured before negotiation completed");
endmodule
`default_nettype wire

//--- rtl/phy_status_autoneg_regs.sv
`default_nettype none
module phy_status_autoneg_regs #(
    parameter logic [15:0] OUI_HIGH = 16'h1357, // Arbitrary value.
    parameter logic [5:0]  OUI_LOW  = 6'h2a,    // Arbitrary value.
    parameter logic [5:0]  MODEL    = 6'h05,    // Arbitrary value.
    parameter logic [3:0]  REVISION = 4'h1      // Arbitrary value.
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [4:0]  reg_index,
    input  wire logic        rd_req,
    input  wire logic        wr_req,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data_q,
    output logic             ack_q,
    input  wire logic        link_up,
    input  wire logic        remote_fault,
    input  wire logic        jabber,
    input  wire logic        an_complete,
    input  wire logic        partner_valid,
    input  wire logic [15:0] partner_word,
    input  wire logic        speed_sel_pin,
    output logic      [15:0] adv_word,
    output logic      [1:0]  pause_mode
);
    typedef struct packed {
        logic        strap_s1;
        logic        strap_s2;
        logic [15:0] adv;
        logic [15:0] partner;
        logic [15:0] rd_data;
        logic        ack;
    } regs_state_t;

    regs_state_t s_q;
    regs_state_t s_d;

    latch_if rfault_if ();
    latch_if link_if ();
    latch_if jabber_if ();

    logic status_read;
    logic adv_write;

    // Advertisement value taken on reset; the strap decides the three speed-dependent abilities.
    function automatic logic [15:0] adv_reset(input logic strap);
        logic [15:0] v;
        v = '0;
        v[phy_regs_pkg::ADV_PAUSE_H:phy_regs_pkg::ADV_PAUSE_L] = phy_regs_pkg::PAUSE_NONE;
        v[phy_regs_pkg::ADV_TX] = 1'b1;
        v[phy_regs_pkg::ADV_TX_FD] = strap;
        v[phy_regs_pkg::ADV_10_FD] = strap;
        v[phy_regs_pkg::ADV_10] = strap;
        v[phy_regs_pkg::SEL_H:0] = phy_regs_pkg::SELECTOR_8023;
        return v;
    endfunction

    // Bits 10 to 6 of the status word are reserved and must read zero.
    localparam logic [15:0] STATUS_RSVD = 16'h07c0;

    // Partner value taken on reset: nothing learnt yet, selector already reads 802.3.
    function automatic logic [15:0] partner_reset();
        logic [15:0] v;
        v = '0;
        v[phy_regs_pkg::SEL_H:0] = phy_regs_pkg::SELECTOR_8023;
        return v;
    endfunction

    // Composes the word returned for one index; unknown indexes read zero.
    function automatic logic [15:0] read_word(
        input logic [4:0]  idx,
        input logic [15:0] adv,
        input logic [15:0] partner,
        input logic        an_done,
        input logic        rf,
        input logic        lnk,
        input logic        jab
    );
        logic [15:0] v;
        v = '0;
        if (idx == phy_regs_pkg::IDX_BASIC_STATUS) begin
            v = phy_regs_pkg::STATUS_FIXED;
            v[phy_regs_pkg::STS_AN_DONE] = an_done;
            v[phy_regs_pkg::STS_RFAULT] = rf;
            v[phy_regs_pkg::STS_LINK] = lnk;
            v[phy_regs_pkg::STS_JABBER] = jab;
        end else if (idx == phy_regs_pkg::IDX_ID_HIGH) begin
            v = OUI_HIGH;
        end else if (idx == phy_regs_pkg::IDX_ID_LOW) begin
            v = {OUI_LOW, MODEL, REVISION};
        end else if (idx == phy_regs_pkg::IDX_ADVERTISE) begin
            v = adv & phy_regs_pkg::ADV_WR_MASK;
        end else if (idx == phy_regs_pkg::IDX_PARTNER) begin
            v = partner & phy_regs_pkg::PARTNER_MASK;
        end else begin
            v = '0;
        end
        return v;
    endfunction

    // The host path is indexed, so every access names one register by its index.
    assign status_read = rd_req && (reg_index == phy_regs_pkg::IDX_BASIC_STATUS);
    assign adv_write = wr_req && !rd_req && (reg_index == phy_regs_pkg::IDX_ADVERTISE);

    assign rfault_if.cond  = remote_fault;
    assign rfault_if.clear = status_read;
    assign link_if.cond    = link_up;
    assign link_if.clear   = status_read;
    assign jabber_if.cond  = jabber;
    assign jabber_if.clear = status_read;

    status_latch #(
        .LATCH_LOW (1'b0)
    ) u_rfault (
        .clock (clock),
        .rst   (rst),
        .lat   (rfault_if.owner)
    );

    status_latch #(
        .LATCH_LOW (1'b1)
    ) u_link (
        .clock (clock),
        .rst   (rst),
        .lat   (link_if.owner)
    );

    status_latch #(
        .LATCH_LOW (1'b0)
    ) u_jabber (
        .clock (clock),
        .rst   (rst),
        .lat   (jabber_if.owner)
    );

    pause_resolve u_pause (
        .clock         (clock),
        .rst           (rst),
        .an_complete   (an_complete),
        .adv_pause     (s_q.adv[phy_regs_pkg::ADV_PAUSE_H:phy_regs_pkg::ADV_PAUSE_L]),
        .partner_pause (s_q.partner[phy_regs_pkg::ADV_PAUSE_H:phy_regs_pkg::ADV_PAUSE_L]),
        .pause_mode    (pause_mode)
    );

    always_comb begin
        s_d = s_q;
        s_d.strap_s1 = speed_sel_pin;
        s_d.strap_s2 = s_q.strap_s1;
        s_d.ack = rd_req || wr_req;
        if (rd_req) begin
            s_d.rd_data = read_word(reg_index, s_q.adv, s_q.partner, an_complete,
                                    rfault_if.shown, link_if.shown, jabber_if.shown);
        end
        // Reserved and read-only bits are dropped by the mask, so a write cannot reach them.
        if (adv_write) begin
            s_d.adv = wr_data & phy_regs_pkg::ADV_WR_MASK;
        end
        // Next page and acknowledge are never kept: next page exchange is not supported.
        if (partner_valid) begin
            s_d.partner = partner_word & phy_regs_pkg::PARTNER_MASK;
        end
    end

    // The strap synchroniser keeps shifting during reset, so reset must last three edges.
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q.strap_s1 <= s_d.strap_s1;
            s_q.strap_s2 <= s_d.strap_s2;
            s_q.adv <= adv_reset(s_q.strap_s2);
            s_q.partner <= partner_reset();
            s_q.rd_data <= '0;
            s_q.ack <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data_q = s_q.rd_data;
    assign ack_q = s_q.ack;
    assign adv_word = s_q.adv;

    // Every check below samples on the one clock and stands down while reset is high.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    fixed_caps_a: assert property (
        (rd_req && reg_index == phy_regs_pkg::IDX_BASIC_STATUS)
        |=> ((rd_data_q & phy_regs_pkg::STATUS_FIXED_MASK) == phy_regs_pkg::STATUS_FIXED))
        else $error("fixed status abilities wrong");
    an_done_a: assert property (
        (rd_req && reg_index == phy_regs_pkg::IDX_BASIC_STATUS)
        |=> (rd_data_q[phy_regs_pkg::STS_AN_DONE] == $past(an_complete)))
        else $error("negotiation complete bit does not follow its source");
    rfault_latch_a: assert property (
        remote_fault ##1 (rd_req && reg_index == phy_regs_pkg::IDX_BASIC_STATUS)
        |=> rd_data_q[phy_regs_pkg::STS_RFAULT])
        else $error("remote fault not latched high");
    link_latch_a: assert property (
        !link_up ##1 (rd_req && reg_index == phy_regs_pkg::IDX_BASIC_STATUS)
        |=> !rd_data_q[phy_regs_pkg::STS_LINK])
        else $error("link loss not latched low");
    jabber_latch_a: assert property (
        jabber ##1 (rd_req && reg_index == phy_regs_pkg::IDX_BASIC_STATUS)
        |=> rd_data_q[phy_regs_pkg::STS_JABBER])
        else $error("jabber not latched high");
    latch_release_a: assert property (
        (status_read && !remote_fault) ##1 (!remote_fault && status_read)
        |=> !rd_data_q[phy_regs_pkg::STS_RFAULT])
        else $error("latched bit not released after a read");
    id_high_a: assert property (
        (rd_req && reg_index == phy_regs_pkg::IDX_ID_HIGH) |=> (rd_data_q == OUI_HIGH))
        else $error("high identifier wrong");
    id_low_a: assert property (
        (rd_req && reg_index == phy_regs_pkg::IDX_ID_LOW)
        |=> (rd_data_q[15:phy_regs_pkg::ID_OUI_L] == OUI_LOW
             && rd_data_q[phy_regs_pkg::ID_OUI_L-1:phy_regs_pkg::ID_MODEL_L] == MODEL
             && rd_data_q[phy_regs_pkg::ID_MODEL_L-1:0] == REVISION))
        else $error("low identifier wrong");
    adv_write_a: assert property (
        adv_write |=> (adv_word == ($past(wr_data) & phy_regs_pkg::ADV_WR_MASK)))
        else $error("advertisement write not stored");
    adv_reserved_a: assert property (
        (adv_word & ~phy_regs_pkg::ADV_WR_MASK) == 16'h0000)
        else $error("reserved advertisement bits set");
    adv_reset_a: assert property (
        $fell(rst) |-> (adv_word[phy_regs_pkg::ADV_TX]
                        && adv_word[phy_regs_pkg::SEL_H:0] == phy_regs_pkg::SELECTOR_8023
                        && adv_word[phy_regs_pkg::ADV_TX_FD] == adv_word[phy_regs_pkg::ADV_10]
                        && adv_word[phy_regs_pkg::ADV_10_FD] == adv_word[phy_regs_pkg::ADV_10]
                        && adv_word[phy_regs_pkg::ADV_PAUSE_H:phy_regs_pkg::ADV_PAUSE_L] == 2'h0
                        && !adv_word[phy_regs_pkg::ADV_RFAULT]))
        else $error("advertisement reset value wrong");
    partner_top_a: assert property (
        (rd_req && reg_index == phy_regs_pkg::IDX_PARTNER)
        |=> (!rd_data_q[phy_regs_pkg::LP_NEXTPAGE] && !rd_data_q[phy_regs_pkg::LP_ACK]))
        else $error("partner next page or acknowledge read as one");
    partner_cap_a: assert property (
        (partner_valid ##1 (rd_req && !partner_valid && reg_index == phy_regs_pkg::IDX_PARTNER))
        |=> (rd_data_q == ($past(partner_word, 2) & phy_regs_pkg::PARTNER_MASK)))
        else $error("partner ability not reflected");
    unmapped_a: assert property (
        (rd_req && (reg_index < phy_regs_pkg::IDX_BASIC_STATUS || reg_index > phy_regs_pkg::IDX_PARTNER))
        |=> (rd_data_q == 16'h0000))
        else $error("unmapped index read nonzero");
    ack_a: assert property (
        (rd_req || wr_req) |=> ack_q)
        else $error("access not acknowledged");

    // Outputs that stand until their own event must not move in between.
    ack_pulse_a: assert property (
        !(rd_req || wr_req) |=> !ack_q)
        else $error("acknowledge without a request");
    rd_hold_a: assert property (
        !rd_req |=> $stable(rd_data_q))
        else $error("read data changed without a read");
    adv_hold_a: assert property (
        !adv_write |=> $stable(adv_word))
        else $error("advertisement changed without a write to it");
    partner_hold_a: assert property (
        !partner_valid |=> $stable(s_q.partner))
        else $error("partner ability changed without a new word");
    status_reserved_a: assert property (
        status_read |=> ((rd_data_q & STATUS_RSVD) == 16'h0000))
        else $error("reserved status bits read nonzero");
    // A read reloads a latched bit, so two reads in a row show the live level.
    link_release_a: assert property (
        (status_read && link_up) ##1 (status_read && link_up)
        |=> rd_data_q[phy_regs_pkg::STS_LINK])
        else $error("link bit not reloaded after a read");
    jabber_release_a: assert property (
        (status_read && !jabber) ##1 (status_read && !jabber)
        |=> !rd_data_q[phy_regs_pkg::STS_JABBER])
        else $error("jabber bit not released after a read");

    // Main scenarios: status read, event during a read, write, link loss and pause choice.
    status_read_c: cover property (status_read ##1 ack_q);
    latch_set_c: cover property ((status_read && remote_fault) ##1 status_read);
    adv_write_c: cover property (adv_write ##1 ack_q);
    link_loss_c: cover property (!link_up ##1 link_up [*2] ##1 status_read);
    pause_pick_c: cover property (an_complete && adv_word[phy_regs_pkg::ADV_PAUSE_H:phy_regs_pkg::ADV_PAUSE_L]
                                  == phy_regs_pkg::PAUSE_BOTH ##1 pause_mode == phy_regs_pkg::PAUSE_SYM);
endmodule
`default_nettype wire

//--- tb/mac_access_model.sv
`default_nettype none
module mac_access_model (
    input  wire logic        clock,
    output logic      [4:0]  reg_index,
    output logic             rd_req,
    output logic             wr_req,
    output logic      [15:0] wr_data,
    input  wire logic [15:0] rd_data_q,
    input  wire logic        ack_q
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_index = 5'h00;
        rd_req    = 1'b0;
        wr_req    = 1'b0;
        wr_data   = 16'h0000;
    end

    // Every register is reached only by its index and a one-cycle request.
    // Released index and data lines show the inverse of the last value, and both requests drop to zero, so stale data never looks valid.
    task automatic access(input logic [4:0] idx, input logic wr, input logic [15:0] data,
                          input int gap, output logic [15:0] rdata, output logic ok);
        ok = 1'b0;
        rdata = 16'h0000;
        repeat (gap) @(posedge clock);
        #2;
        reg_index = idx;
        rd_req = !wr;
        wr_req = wr;
        wr_data = data;
        @(posedge clock);
        #2;
        rd_req = 1'b0;
        wr_req = 1'b0;
        reg_index = ~idx;
        wr_data = ~data;
        for (int i = 0; i < 4; i++) begin
            if (ack_q === 1'b1) begin
                ok = 1'b1;
                rdata = rd_data_q;
                break;
            end
            @(posedge clock);
            #2;
        end
    endtask
endmodule
`default_nettype wire

//--- tb/phy_status_autoneg_regs_tb.sv
`default_nettype none
module phy_status_autoneg_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] OUI_H = 16'h2468; // Arbitrary value.
    localparam logic [5:0]  OUI_L = 6'h15;    // Arbitrary value.
    localparam logic [5:0]  MDL   = 6'h0c;    // Arbitrary value.
    localparam logic [3:0]  REV   = 4'h3;     // Arbitrary value.

    logic        clock, rst, rd_req, wr_req, ack_q, link_up, remote_fault, jabber;
    logic        an_complete, partner_valid, speed_sel_pin, ok;
    logic [4:0]  reg_index;
    logic [1:0]  pause_mode;
    logic [15:0] wr_data, rd_data_q, partner_word, adv_word, rnd, got, adv_m, partner_m;
    int          mismatches, total_checks;

    phy_status_autoneg_regs #(.OUI_HIGH(OUI_H), .OUI_LOW(OUI_L), .MODEL(MDL), .REVISION(REV)) dut_u (
        .clock(clock), .rst(rst), .reg_index(reg_index), .rd_req(rd_req), .wr_req(wr_req),
        .wr_data(wr_data), .rd_data_q(rd_data_q), .ack_q(ack_q), .link_up(link_up),
        .remote_fault(remote_fault), .jabber(jabber), .an_complete(an_complete),
        .partner_valid(partner_valid), .partner_word(partner_word), .speed_sel_pin(speed_sel_pin),
        .adv_word(adv_word), .pause_mode(pause_mode));

    mac_access_model mac_u (
        .clock(clock), .reg_index(reg_index), .rd_req(rd_req), .wr_req(wr_req),
        .wr_data(wr_data), .rd_data_q(rd_data_q), .ack_q(ack_q));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        total_checks++;
        if (seen !== expd) begin
            mismatches++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic bus(input logic [4:0] idx, input logic wr, input logic [15:0] data);
        mac_u.access(idx, wr, data, 0, got, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            finish_test();
        end
    endtask

    task automatic rd_chk(input logic [4:0] idx, input logic [15:0] expd);
        bus(idx, 1'b0, 16'h0000);
        check(got, expd);
    endtask

    task automatic do_reset(input logic strap);
        speed_sel_pin = strap;
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        adv_m = 16'h0081 | (strap ? 16'h0160 : 16'h0000);
        partner_m = 16'h0001;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [15:0] status_m(input logic an, input logic rf, input logic lnk, input logic jab);
        return 16'h7809 | {10'h000, an, rf, 1'b0, lnk, jab, 1'b0};
    endfunction

    function automatic logic [15:0] model_rd(input logic [4:0] idx);
        case (idx)
            5'h02:   return OUI_H;
            5'h03:   return {OUI_L, MDL, REV};
            5'h04:   return adv_m;
            5'h05:   return partner_m;
            default: return 16'h0000;
        endcase
    endfunction

    // Offering both pauses must settle on at most one of them, symmetric preferred; none if the partner offers neither.
    function automatic logic [1:0] pause_m(input logic [1:0] a, input logic [1:0] b);
        if (a != 2'h3) return a;
        if (b[0]) return 2'h1;
        return b[1] ? 2'h2 : 2'h0;
    endfunction

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        finish_test();
    end

    initial begin
        mismatches = 0;
        total_checks = 0;
        rst = 1'b1;
        {link_up, remote_fault, jabber, an_complete, partner_valid} = 5'h00;
        partner_word = 16'h0000;
        speed_sel_pin = 1'b1;
        rnd = 16'h2e19;
        do_reset(1'b1);
        check(adv_word, adv_m);
        for (int i = 0; i < 8; i++) begin
            if (i != 1) rd_chk(5'(i), model_rd(5'(i)));
        end
        rd_chk(5'h01, status_m(1'b0, 1'b0, 1'b0, 1'b0));
        link_up = 1'b1;
        tick(3);
        rd_chk(5'h01, status_m(1'b0, 1'b0, 1'b0, 1'b0));
        rd_chk(5'h01, status_m(1'b0, 1'b0, 1'b1, 1'b0));
        {remote_fault, jabber, link_up} = 3'h6;
        tick(1);
        {remote_fault, jabber, link_up} = 3'h1;
        tick(3);
        rd_chk(5'h01, status_m(1'b0, 1'b1, 1'b0, 1'b1));
        rd_chk(5'h01, status_m(1'b0, 1'b0, 1'b1, 1'b0));
        // Faults still present in the reading cycle must survive that read.
        {remote_fault, jabber} = 2'h3;
        tick(1);
        rd_chk(5'h01, status_m(1'b0, 1'b1, 1'b1, 1'b1));
        {remote_fault, jabber} = 2'h0;
        rd_chk(5'h01, status_m(1'b0, 1'b1, 1'b1, 1'b1));
        rd_chk(5'h01, status_m(1'b0, 1'b0, 1'b1, 1'b0));
        an_complete = 1'b1;
        tick(2);
        rd_chk(5'h01, status_m(1'b1, 1'b0, 1'b1, 1'b0));
        an_complete = 1'b0;
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            bus(5'h04, 1'b1, rnd);
            adv_m = rnd & 16'h2dff;
            check(adv_word, adv_m);
            bus((i == 4) ? 5'h07 : 5'(i), 1'b1, ~rnd);
            rd_chk(5'h04, adv_m);
        end
        for (int i = 2; i < 6; i++) rd_chk(5'(i), model_rd(5'(i)));
        for (int p = 0; p < 4; p++) begin
            for (int q = 0; q < 4; q++) begin
                rnd = lfsr(rnd);
                bus(5'h04, 1'b1, {rnd[15:12], 2'(p), rnd[9:0]});
                adv_m = {rnd[15:12], 2'(p), rnd[9:0]} & 16'h2dff;
                partner_word = {rnd[3:0], 2'(q), rnd[15:6]};
                partner_valid = 1'b1;
                tick(1);
                partner_valid = 1'b0;
                partner_m = partner_word & 16'h2fff;
                partner_word = ~partner_word;
                rd_chk(5'h05, partner_m);
                check({14'h0000, pause_mode}, 16'h0000);
                an_complete = 1'b1;
                tick(2);
                check({14'h0000, pause_mode}, {14'h0000, pause_m(2'(p), 2'(q))});
                an_complete = 1'b0;
                tick(2);
            end
        end
        do_reset(1'b0);
        check(adv_word, adv_m);
        rd_chk(5'h05, partner_m);
        rd_chk(5'h01, status_m(1'b0, 1'b0, 1'b0, 1'b0));
        finish_test();
    end
endmodule
`default_nettype wire
